/* cal_if.sv */
interface cal_if;
  logic        start;
  logic [1:0]  source;
  logic [4:0]  divisor;
  logic        done;
  logic [19:0] count;

  modport ctrl (output start, output source, output divisor,
                input done, input count);
  modport unit (input start, input source, input divisor,
                output done, output count);
endinterface

/* rf_control_sleep_calibration_regs.sv */
// Functional notes
// R1: Upper nibble codes select battery trip level
// R2: Bit 3 enables battery monitor, reset off
// R3: Low-battery flag reported outside these registers
// R4: Host should set transmit filter bit
// R5: Bit 4 selects fast main clock recovery
// R6: Source field picks internal or external oscillator
// R7: Host should set VCO tuning bit
// R8: Host writes reserved bits as zero
// R9: Twenty-bit count split over three registers
// R10: Count spans 16 sleep periods, 50 ns ticks
// R11: Measure the divided sleep clock in use
// R12: Write one starts calibration, self-clearing
// R13: Ready flag set when count completes
// R14: Read-only radio state in bits 7-5
// R15: Averaged signal strength readable, read-only
// R16: Sleep clock is source over 2^divisor
// R17: Internal oscillator needs divisor at least one
// R18: New start clears ready, keeps old count
// R19: Battery flag updates only while monitor enabled
// R20: Writable fields reset zero, status reads zero
module rf_control_sleep_calibration_regs #(
  parameter int CAL_COUNT_W = 20,
  parameter int FAST_RECOVERY_CYCLES =
    rf_regs_pkg::FAST_RECOVERY_US * rf_regs_pkg::NS_PER_US
    / rf_regs_pkg::CLK_PERIOD_NS,
  parameter int SLOW_RECOVERY_CYCLES =
    rf_regs_pkg::SLOW_RECOVERY_US * rf_regs_pkg::NS_PER_US
    / rf_regs_pkg::CLK_PERIOD_NS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        int_osc_i,
  input  wire logic        ext_osc_i,
  input  wire logic [3:0]  supply_level_i,
  input  wire logic [2:0]  radio_state_field_i,
  input  wire logic [7:0]  strength_i,
  input  wire logic        strength_valid_i,
  input  wire logic        wake_request_i,
  output logic             battery_low_flag_o,
  output logic             battery_monitor_on_o,
  output logic [3:0]       battery_trip_level_o,
  output logic             transmit_filter_ctl_o,
  output logic             main_clock_fast_recovery_o,
  output logic [1:0]       sleep_clock_source_o,
  output logic             vco_tune_bit_o,
  output logic [4:0]       sleep_clock_divisor_o,
  output logic             main_clock_ready_o
);
  localparam int AW  = rf_regs_pkg::ADDR_W;
  localparam int DW  = rf_regs_pkg::DATA_W;
  localparam int BW  = rf_regs_pkg::BYTE_W;
  localparam int RCW = 17;

  if (CAL_COUNT_W != 20) begin : g_bad_width
    $error("Count width must be 20");
  end
  if (SLOW_RECOVERY_CYCLES >= (1 << RCW) || FAST_RECOVERY_CYCLES < 1 ||
      SLOW_RECOVERY_CYCLES < 1) begin : g_bad_recovery
    $error("Bad recovery counts");
  end

  function automatic logic hit(input logic [AW-1:0] addr,
                               input logic [rf_regs_pkg::IDX_W-1:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  function automatic logic mapped(input logic [AW-1:0] addr);
    mapped = hit(addr, rf_regs_pkg::IDX_BATT_THRESH) ||
             hit(addr, rf_regs_pkg::IDX_TXF_REC_BAT) ||
             hit(addr, rf_regs_pkg::IDX_SLEEP_SRC)   ||
             hit(addr, rf_regs_pkg::IDX_VCO_TUNE)    ||
             hit(addr, rf_regs_pkg::IDX_CAL_LOW)     ||
             hit(addr, rf_regs_pkg::IDX_CAL_MID)     ||
             hit(addr, rf_regs_pkg::IDX_CAL_HIGH)    ||
             hit(addr, rf_regs_pkg::IDX_RADIO_STATE) ||
             hit(addr, rf_regs_pkg::IDX_STRENGTH)    ||
             hit(addr, rf_regs_pkg::IDX_SLEEP_DIV);
  endfunction

  cal_if cal_bus ();

  sleep_cal_unit #(
    .COUNT_W (CAL_COUNT_W)
  ) u_cal (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .int_osc_i (int_osc_i),
    .ext_osc_i (ext_osc_i),
    .cal       (cal_bus.unit)
  );

  // Bus state
  logic          aw_held;
  logic          next_aw_held;
  logic          w_held;
  logic          next_w_held;
  logic [AW-1:0] aw_addr;
  logic [AW-1:0] next_aw_addr;
  logic [BW-1:0] w_byte;
  logic [BW-1:0] next_w_byte;
  logic          w_lane;
  logic          next_w_lane;
  logic          next_awready;
  logic          next_wready;
  logic          next_bvalid;
  logic [1:0]    next_bresp;
  logic          next_arready;
  logic          next_rvalid;
  logic [1:0]    next_rresp;
  logic [DW-1:0] next_rdata;
  logic          do_write;
  logic [BW-1:0] rd_byte;

  // Register state
  logic [3:0]    next_trip;
  logic          next_transmit_filter_ctl;
  logic          next_fast_rec;
  logic          next_bat_on;
  logic [1:0]    next_src;
  logic          next_vco;
  logic [4:0]    next_div;
  logic          cal_start;
  logic          next_cal_start;
  logic [2:0]    radio_state;
  logic [2:0]    next_radio_state;
  logic [7:0]    strength;
  logic [7:0]    next_strength;
  logic          next_bat_low;
  logic [RCW-1:0] wake_cnt;
  logic [RCW-1:0] next_wake_cnt;
  logic          next_clk_ready;

  assign cal_bus.start   = cal_start;
  assign cal_bus.source  = sleep_clock_source_o;
  assign cal_bus.divisor = sleep_clock_divisor_o;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bvalid  = s_axi_bvalid_o;
    next_bresp   = s_axi_bresp_o;
    next_rvalid  = s_axi_rvalid_o;
    next_rresp   = s_axi_rresp_o;
    next_rdata   = s_axi_rdata_o;
    rd_byte      = '0;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata_i[BW-1:0];
      next_w_lane = s_axi_wstrb_i[0];
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    do_write = aw_held && w_held && !s_axi_bvalid_o;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? rf_regs_pkg::RESP_OKAY
                                     : rf_regs_pkg::RESP_SLVERR;
    end
    next_awready = !next_aw_held;
    next_wready  = !next_w_held;
    // Read mux; reserved and write-only bits read zero
    if (hit(s_axi_araddr_i, rf_regs_pkg::IDX_BATT_THRESH)) begin
      rd_byte[rf_regs_pkg::TRIP_LSB +: rf_regs_pkg::TRIP_W] =
        battery_trip_level_o;
    end else if (hit(s_axi_araddr_i, rf_regs_pkg::IDX_TXF_REC_BAT)) begin
      rd_byte[rf_regs_pkg::TRANSMIT_FILTER_CTL_BIT]    = transmit_filter_ctl_o;
      rd_byte[rf_regs_pkg::RECOVERY_BIT] = main_clock_fast_recovery_o;
      rd_byte[rf_regs_pkg::BATTERY_MONITOR_ON_BIT]    = battery_monitor_on_o;
    end else if (hit(s_axi_araddr_i, rf_regs_pkg::IDX_SLEEP_SRC)) begin
      rd_byte[rf_regs_pkg::SRC_LSB +: rf_regs_pkg::SRC_W] =
        sleep_clock_source_o;
    end else if (hit(s_axi_araddr_i, rf_regs_pkg::IDX_VCO_TUNE)) begin
      rd_byte[rf_regs_pkg::VCO_BIT] = vco_tune_bit_o;
    end else if (hit(s_axi_araddr_i, rf_regs_pkg::IDX_CAL_LOW)) begin
      rd_byte = cal_bus.count[7:0]; // R9
    end else if (hit(s_axi_araddr_i, rf_regs_pkg::IDX_CAL_MID)) begin
      rd_byte = cal_bus.count[15:8]; // R9
    end else if (hit(s_axi_araddr_i, rf_regs_pkg::IDX_CAL_HIGH)) begin
      rd_byte[rf_regs_pkg::CAL_RDY_BIT] = cal_bus.done; // R13
      rd_byte[rf_regs_pkg::CAL_TOP_LSB +: 4] = cal_bus.count[19:16]; // R9
    end else if (hit(s_axi_araddr_i, rf_regs_pkg::IDX_RADIO_STATE)) begin
      rd_byte[rf_regs_pkg::STATE_LSB +: rf_regs_pkg::STATE_W] =
        radio_state; // R14
    end else if (hit(s_axi_araddr_i, rf_regs_pkg::IDX_STRENGTH)) begin
      rd_byte = strength; // R15
    end else if (hit(s_axi_araddr_i, rf_regs_pkg::IDX_SLEEP_DIV)) begin
      rd_byte[rf_regs_pkg::DIV_W-1:0] = sleep_clock_divisor_o;
    end
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rdata  = {{(DW-BW){1'b0}}, rd_byte};
      next_rresp  = mapped(s_axi_araddr_i) ? rf_regs_pkg::RESP_OKAY
                                           : rf_regs_pkg::RESP_SLVERR;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= '0;
      w_byte          <= '0;
      w_lane          <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= rf_regs_pkg::RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= rf_regs_pkg::RESP_OKAY;
      s_axi_rdata_o   <= '0;
    end else begin
      aw_held         <= next_aw_held;
      w_held          <= next_w_held;
      aw_addr         <= next_aw_addr;
      w_byte          <= next_w_byte;
      w_lane          <= next_w_lane;
      s_axi_awready_o <= next_awready;
      s_axi_wready_o  <= next_wready;
      s_axi_bvalid_o  <= next_bvalid;
      s_axi_bresp_o   <= next_bresp;
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o  <= next_rvalid;
      s_axi_rresp_o   <= next_rresp;
      s_axi_rdata_o   <= next_rdata;
    end
  end

  // Only byte lane 0 carries register data
  always_comb begin
    next_trip        = battery_trip_level_o;
    next_transmit_filter_ctl       = transmit_filter_ctl_o;
    next_fast_rec    = main_clock_fast_recovery_o;
    next_bat_on      = battery_monitor_on_o;
    next_src         = sleep_clock_source_o;
    next_vco         = vco_tune_bit_o;
    next_div         = sleep_clock_divisor_o;
    next_cal_start   = 1'b0; // R12
    next_radio_state = radio_state_field_i; // R14
    next_strength    = strength;
    next_bat_low     = battery_low_flag_o;
    next_wake_cnt    = wake_cnt;
    next_clk_ready   = main_clock_ready_o;
    if (do_write && w_lane) begin
      if (hit(aw_addr, rf_regs_pkg::IDX_BATT_THRESH)) begin
        next_trip = w_byte[rf_regs_pkg::TRIP_LSB +: rf_regs_pkg::TRIP_W];
      end else if (hit(aw_addr, rf_regs_pkg::IDX_TXF_REC_BAT)) begin
        next_transmit_filter_ctl    = w_byte[rf_regs_pkg::TRANSMIT_FILTER_CTL_BIT];
        next_fast_rec = w_byte[rf_regs_pkg::RECOVERY_BIT]; // R5
        next_bat_on   = w_byte[rf_regs_pkg::BATTERY_MONITOR_ON_BIT]; // R2
      end else if (hit(aw_addr, rf_regs_pkg::IDX_SLEEP_SRC)) begin
        next_src = w_byte[rf_regs_pkg::SRC_LSB +: rf_regs_pkg::SRC_W]; // R6
      end else if (hit(aw_addr, rf_regs_pkg::IDX_VCO_TUNE)) begin
        next_vco = w_byte[rf_regs_pkg::VCO_BIT];
      end else if (hit(aw_addr, rf_regs_pkg::IDX_CAL_HIGH)) begin
        next_cal_start = w_byte[rf_regs_pkg::CAL_EN_BIT]; // R12
      end else if (hit(aw_addr, rf_regs_pkg::IDX_SLEEP_DIV)) begin
        next_div = w_byte[rf_regs_pkg::DIV_W-1:0]; // R16
      end
    end
    if (strength_valid_i) begin
      next_strength = strength_i; // R15
    end
    // Frozen while off; undefined codes never trip
    if (battery_monitor_on_o) begin
      next_bat_low = (battery_trip_level_o >= rf_regs_pkg::TRIP_MIN) &&
                     (battery_trip_level_o <= rf_regs_pkg::TRIP_MAX) &&
                     (supply_level_i < battery_trip_level_o); // R1 R19 R3
    end
    // Settling bound chosen by bit 4
    if (wake_request_i) begin
      next_clk_ready = 1'b0;
      next_wake_cnt  = main_clock_fast_recovery_o
                       ? RCW'(FAST_RECOVERY_CYCLES)
                       : RCW'(SLOW_RECOVERY_CYCLES); // R5
    end else if (wake_cnt != '0) begin
      next_wake_cnt = wake_cnt - RCW'(1);
      if (wake_cnt == RCW'(1)) begin
        next_clk_ready = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      battery_trip_level_o       <= '0; // R20
      transmit_filter_ctl_o      <= 1'b0;
      main_clock_fast_recovery_o <= 1'b0;
      battery_monitor_on_o       <= 1'b0;
      sleep_clock_source_o       <= '0;
      vco_tune_bit_o             <= 1'b0;
      sleep_clock_divisor_o      <= '0;
      cal_start                  <= 1'b0;
      radio_state                <= '0;
      strength                   <= '0;
      battery_low_flag_o         <= 1'b0;
      wake_cnt                   <= '0;
      main_clock_ready_o         <= 1'b0;
    end else begin
      battery_trip_level_o       <= next_trip;
      transmit_filter_ctl_o      <= next_transmit_filter_ctl;
      main_clock_fast_recovery_o <= next_fast_rec;
      battery_monitor_on_o       <= next_bat_on;
      sleep_clock_source_o       <= next_src;
      vco_tune_bit_o             <= next_vco;
      sleep_clock_divisor_o      <= next_div;
      cal_start                  <= next_cal_start;
      radio_state                <= next_radio_state;
      strength                   <= next_strength;
      battery_low_flag_o         <= next_bat_low;
      wake_cnt                   <= next_wake_cnt;
      main_clock_ready_o         <= next_clk_ready;
    end
  end
endmodule

/* rf_regs_asserts.sv */
module rf_regs_asserts #(
  parameter int FAST_RECOVERY_CYCLES = 5,
  parameter int SLOW_RECOVERY_CYCLES = 12
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [1:0]  s_axi_bresp_o,
  input  wire logic        s_axi_rvalid_o,
  input  wire logic [31:0] s_axi_rdata_o,
  input  wire logic [3:0]  supply_level_i,
  input  wire logic        wake_request_i,
  input  wire logic        battery_low_flag_o,
  input  wire logic        battery_monitor_on_o,
  input  wire logic [3:0]  battery_trip_level_o,
  input  wire logic        main_clock_fast_recovery_o,
  input  wire logic        main_clock_ready_o
);
  localparam int FAST_LO = FAST_RECOVERY_CYCLES - 1;
  localparam int FAST_HI = FAST_RECOVERY_CYCLES + 2;
  localparam int SLOW_LO = SLOW_RECOVERY_CYCLES - 1;
  localparam int SLOW_HI = SLOW_RECOVERY_CYCLES + 2;
  wire logic low_cond = battery_trip_level_o >= 4'h7
    && battery_trip_level_o <= 4'he && supply_level_i < battery_trip_level_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !s_axi_bvalid_o && !s_axi_rvalid_o && !battery_monitor_on_o
    && battery_trip_level_o == 4'h0 && !main_clock_ready_o)
    else $error("reset");
  a_batt_hold: assert property (!battery_monitor_on_o |=>
    $stable(battery_low_flag_o)) else $error("flag moved");
  a_batt_follow: assert property (battery_monitor_on_o |=>
    battery_low_flag_o == $past(low_cond)) else $error("bad flag");
  a_fast_recov: assert property (
    wake_request_i && main_clock_fast_recovery_o |->
    ##[FAST_LO:FAST_HI] main_clock_ready_o) else $error("fast late");
  a_slow_wait: assert property (
    wake_request_i && !main_clock_fast_recovery_o |=>
    (!main_clock_ready_o) [*8]) else $error("slow early");
  a_slow_done: assert property (
    wake_request_i && !main_clock_fast_recovery_o |->
    ##[SLOW_LO:SLOW_HI] main_clock_ready_o) else $error("slow late");
  a_rdata_upper: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:8] == 24'h0) else $error("rdata high");
  a_bvalid_drop: assert property (s_axi_bvalid_o && s_axi_bready_i
    |=> !s_axi_bvalid_o) else $error("bvalid held");
  c_batt_low: cover property (battery_low_flag_o);
  c_fast: cover property (wake_request_i && main_clock_fast_recovery_o);
  c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
endmodule
bind rf_control_sleep_calibration_regs rf_regs_asserts #(
  .FAST_RECOVERY_CYCLES(FAST_RECOVERY_CYCLES),
  .SLOW_RECOVERY_CYCLES(SLOW_RECOVERY_CYCLES)
) chk (.*);

/* rf_regs_pkg.sv */
package rf_regs_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 10;

  // Register indices; byte address = 4 * index
  localparam logic [IDX_W-1:0] IDX_BATT_THRESH = 10'h205;
  localparam logic [IDX_W-1:0] IDX_TXF_REC_BAT = 10'h206;
  localparam logic [IDX_W-1:0] IDX_SLEEP_SRC   = 10'h207;
  localparam logic [IDX_W-1:0] IDX_VCO_TUNE    = 10'h208;
  localparam logic [IDX_W-1:0] IDX_CAL_LOW     = 10'h209;
  localparam logic [IDX_W-1:0] IDX_CAL_MID     = 10'h20a;
  localparam logic [IDX_W-1:0] IDX_CAL_HIGH    = 10'h20b;
  localparam logic [IDX_W-1:0] IDX_RADIO_STATE = 10'h20f;
  localparam logic [IDX_W-1:0] IDX_STRENGTH    = 10'h210;
  localparam logic [IDX_W-1:0] IDX_SLEEP_DIV   = 10'h220;

  // Field positions
  localparam int TRIP_LSB     = 4;
  localparam int TRIP_W       = 4;
  localparam int TRANSMIT_FILTER_CTL_BIT    = 7;
  localparam int RECOVERY_BIT = 4;
  localparam int BATTERY_MONITOR_ON_BIT    = 3;
  localparam int SRC_LSB      = 6;
  localparam int SRC_W        = 2;
  localparam int VCO_BIT      = 4;
  localparam int CAL_RDY_BIT  = 7;
  localparam int CAL_EN_BIT   = 4;
  localparam int CAL_TOP_LSB  = 0;
  localparam int STATE_LSB    = 5;
  localparam int STATE_W      = 3;
  localparam int DIV_W        = 5;
  localparam int BYTE_W       = 8;

  // Valid trip-level codes, 2.5 V up to 3.5 V
  localparam logic [TRIP_W-1:0] TRIP_MIN = 4'h7;
  localparam logic [TRIP_W-1:0] TRIP_MAX = 4'he;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Calibration timing
  localparam int CAL_PERIODS   = 16;
  localparam int TICK_NS       = 50;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACC_W         = 7;

  // Main clock recovery bounds
  localparam int FAST_RECOVERY_US = 1;
  localparam int SLOW_RECOVERY_US = 3;
  localparam int NS_PER_US        = 1000;

  typedef enum logic [1:0] {
    SRC_NONE     = 2'b00,
    SRC_EXTERNAL = 2'b01,
    SRC_INTERNAL = 2'b10
  } sleep_source_e;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_ARM  = 2'b01,
    CAL_RUN  = 2'b10
  } cal_state_e;

endpackage

/* sleep_cal_unit.sv */
module sleep_cal_unit #(
  parameter int COUNT_W = 20
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic int_osc_i,
  input  wire logic ext_osc_i,
  cal_if.unit       cal
);
  localparam int EDGE_W = 4 + 32;
  localparam int ACC_W  = rf_regs_pkg::ACC_W;

  rf_regs_pkg::cal_state_e state;
  rf_regs_pkg::cal_state_e next_state;
  logic               src_q;
  logic               next_src_q;
  logic [ACC_W-1:0]   acc;
  logic [ACC_W-1:0]   next_acc;
  logic [COUNT_W-1:0] run;
  logic [COUNT_W-1:0] next_run;
  logic [EDGE_W-1:0]  edges;
  logic [EDGE_W-1:0]  next_edges;
  logic [COUNT_W-1:0] result;
  logic [COUNT_W-1:0] next_result;
  logic               done;
  logic               next_done;
  logic               src;
  logic               rise;
  logic               tick;
  logic [ACC_W-1:0]   acc_sum;
  logic [COUNT_W-1:0] run_inc;
  logic [EDGE_W-1:0]  needed;

  assign cal.done  = done;
  assign cal.count = result;

  always_comb begin
    src = 1'b0;
    if (cal.source == rf_regs_pkg::SRC_INTERNAL) begin
      src = int_osc_i;
    end else if (cal.source == rf_regs_pkg::SRC_EXTERNAL) begin
      src = ext_osc_i;
    end
    rise   = src & ~src_q;
    // 2^n source periods each
    needed = EDGE_W'(rf_regs_pkg::CAL_PERIODS) << cal.divisor; // R16 R11
    acc_sum = acc + ACC_W'(rf_regs_pkg::CLK_PERIOD_NS);
    tick    = 1'b0;
    if (acc_sum >= ACC_W'(rf_regs_pkg::TICK_NS)) begin
      tick    = 1'b1;
      acc_sum = acc_sum - ACC_W'(rf_regs_pkg::TICK_NS); // R10
    end
    // Saturate, never wrap
    run_inc = run;
    if (tick && (run != {COUNT_W{1'b1}})) begin
      run_inc = run + COUNT_W'(1);
    end
    next_src_q  = src;
    next_state  = state;
    next_acc    = acc;
    next_run    = run;
    next_edges  = edges;
    next_result = result;
    next_done   = done;
    case (state)
      rf_regs_pkg::CAL_IDLE: begin
        next_state = state;
      end
      rf_regs_pkg::CAL_ARM: begin
        if (rise) begin
          next_state = rf_regs_pkg::CAL_RUN;
          next_acc   = '0;
          next_run   = '0;
          next_edges = '0;
        end
      end
      rf_regs_pkg::CAL_RUN: begin
        next_acc = acc_sum;
        next_run = run_inc;
        if (rise) begin
          if (edges + EDGE_W'(1) == needed) begin
            next_result = run_inc; // R10
            next_done   = 1'b1; // R13
            next_state  = rf_regs_pkg::CAL_IDLE;
          end else begin
            next_edges = edges + EDGE_W'(1);
          end
        end
      end
      default: begin
        next_state = rf_regs_pkg::CAL_IDLE;
      end
    endcase
    // Restart drops flag, keeps result
    if (cal.start) begin
      next_state = rf_regs_pkg::CAL_ARM;
      next_done  = 1'b0; // R18
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= rf_regs_pkg::CAL_IDLE;
      src_q  <= 1'b0;
      acc    <= '0;
      run    <= '0;
      edges  <= '0;
      result <= '0;
      done   <= 1'b0;
    end else begin
      state  <= next_state;
      src_q  <= next_src_q;
      acc    <= next_acc;
      run    <= next_run;
      edges  <= next_edges;
      result <= next_result;
      done   <= next_done;
    end
  end
endmodule

/* sleep_osc_model.sv */
module sleep_osc_model #(
  parameter int INT_HALF = 3,
  parameter int EXT_HALF = 10
) (
  input  wire logic clk_i,
  output logic      int_osc_o,
  output logic      ext_osc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int ci = 0;
  int ce = 0;
  initial begin
    int_osc_o = 1'b0;
    ext_osc_o = 1'b0;
  end
  always @(posedge clk_i) begin
    ci <= (ci == INT_HALF - 1) ? 0 : ci + 1;
    ce <= (ce == EXT_HALF - 1) ? 0 : ce + 1;
    if (ci == INT_HALF - 1) int_osc_o <= ~int_osc_o;
    if (ce == EXT_HALF - 1) ext_osc_o <= ~ext_osc_o;
  end
endmodule

/* tb_rf_control_sleep_calibration_regs.sv */
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_rf_control_sleep_calibration_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_rready_i, strength_valid_i;
  logic        wake_request_i, s_axi_awready_o, s_axi_wready_o;
  logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic        battery_low_flag_o, battery_monitor_on_o, vco_tune_bit_o;
  logic        transmit_filter_ctl_o, main_clock_fast_recovery_o;
  logic        main_clock_ready_o;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i, supply_level_i, battery_trip_level_o;
  logic [2:0]  radio_state_field_i;
  logic [7:0]  strength_i, rd;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, sleep_clock_source_o, rs;
  logic [4:0]  sleep_clock_divisor_o;
  wire logic   int_osc_i, ext_osc_i;
  int          num_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  rf_control_sleep_calibration_regs #(.FAST_RECOVERY_CYCLES(5),
    .SLOW_RECOVERY_CYCLES(12)) DUT (.*);
  sleep_osc_model #(.INT_HALF(3), .EXT_HALF(10)) osc (.clk_i,
    .int_osc_o(int_osc_i), .ext_osc_o(ext_osc_i));
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    s_axi_awaddr_i <= {idx, 2'b00};
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    rs = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [9:0] idx);
    @(posedge clk_i);
    s_axi_araddr_i <= {idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    rd = s_axi_rdata_o[7:0];
    rs = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e);
    rd_reg(idx);
    `CHK(rd, e)
  endtask
  task automatic get_cnt(output logic [19:0] c);
    rd_reg(10'h209);
    c[7:0] = rd;
    rd_reg(10'h20a);
    c[15:8] = rd;
    rd_reg(10'h20b);
    c[19:16] = rd[3:0];
  endtask
  task automatic t_reset();
    for (int k = 'h205; k <= 'h210; k++) rd_chk(10'(k), 8'h00);
    rd_chk(10'h220, 8'h00);
  endtask
  task automatic t_fields();
    wr(10'h206, 8'h98);
    rd_chk(10'h206, 8'h98);
    `CHK({transmit_filter_ctl_o, main_clock_fast_recovery_o}, 2'b11)
    `CHK(battery_monitor_on_o, 1'b1)
    wr(10'h208, 8'h10);
    rd_chk(10'h208, 8'h10);
    `CHK(vco_tune_bit_o, 1'b1)
    for (int s = 1; s < 3; s++) begin
      wr(10'h207, 8'(s << 6));
      `CHK(sleep_clock_source_o, 2'(s))
    end
  endtask
  task automatic t_batt();
    supply_level_i <= 4'h6;
    for (int c = 0; c < 16; c++) begin
      wr(10'h205, 8'(c << 4));
      repeat (3) @(posedge clk_i);
      `CHK(battery_trip_level_o, 4'(c))
      `CHK(battery_low_flag_o, 1'(c >= 7 && c <= 14))
    end
    wr(10'h205, 8'he0);
    supply_level_i <= 4'hf;
    repeat (3) @(posedge clk_i);
    `CHK(battery_low_flag_o, 1'b0)
    wr(10'h206, 8'h90);
    supply_level_i <= 4'h0;
    repeat (3) @(posedge clk_i);
    `CHK(battery_low_flag_o, 1'b0)
  endtask
  task automatic t_status();
    for (int s = 0; s < 8; s++) begin
      radio_state_field_i <= 3'(s);
      repeat (2) @(posedge clk_i);
      rd_chk(10'h20f, 8'(s << 5));
    end
    strength_i <= 8'h5a;
    strength_valid_i <= 1'b1;
    @(posedge clk_i);
    strength_valid_i <= 1'b0;
    strength_i <= 8'h00;
    rd_chk(10'h210, 8'h5a);
    wr(10'h209, 8'hff);
    rd_chk(10'h209, 8'h00);
    wr(10'h300, 8'h01);
    `CHK(rs, rf_regs_pkg::RESP_SLVERR)
    rd_chk(10'h300, 8'h00);
    `CHK(rs, rf_regs_pkg::RESP_SLVERR)
  endtask
  // One tick of phase slack
  task automatic t_cal(input logic [7:0] src, input int dv, input int per);
    logic [19:0] old, cnt;
    int          i, e;
    e = rf_regs_pkg::CAL_PERIODS * (2 ** dv) * per
      * rf_regs_pkg::CLK_PERIOD_NS / rf_regs_pkg::TICK_NS;
    get_cnt(old);
    wr(10'h207, src);
    wr(10'h220, 8'(dv));
    `CHK(sleep_clock_divisor_o, 5'(dv))
    wr(10'h20b, 8'h10);
    rd_reg(10'h20b);
    `CHK(rd[7], 1'b0)
    get_cnt(cnt);
    `CHK(cnt, old)
    i = 0;
    do begin
      rd_reg(10'h20b);
      i++;
    end while (rd[7] !== 1'b1 && i < 400);
    `CHK(rd[7:4], 4'h8)
    get_cnt(cnt);
    `CHK(int'(cnt) >= e - 1 && int'(cnt) <= e + 1, 1'b1)
  endtask
  task automatic t_recov(input logic [7:0] cfg, input int lim);
    int i;
    wr(10'h206, cfg);
    wake_request_i <= 1'b1;
    @(posedge clk_i);
    wake_request_i <= 1'b0;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (main_clock_ready_o !== 1'b1 && i < 40);
    `CHK(i >= lim - 1 && i <= lim + 2, 1'b1)
  endtask
  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    {rst_i, s_axi_wstrb_i} = 5'h11;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
    {s_axi_arvalid_i, s_axi_rready_i, wake_request_i} = 3'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    {supply_level_i, radio_state_field_i, strength_i} = '0;
    strength_valid_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_batt();
    t_status();
    t_cal(8'h80, 1, 6);
    t_cal(8'h40, 0, 20);
    t_recov(8'h90, 5);
    t_recov(8'h80, 12);
    complete_run();
  end
endmodule
